// ### image_sensor_frame_readout_lvds_tb.sv
// Self-checking bench: SPI register access, lane enables, frame starts.
// Assumes the pixel source model and the readout block compile before it.
`default_nettype none
module image_sensor_frame_readout_lvds_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   // Reset starts inactive and select starts active so their first edges clear the SPI flops
   logic clk = 0, rst_n = 1, sclk = 0, cs_n = 0, mosi = 0, trig = 0;
   logic [1:0] depth = 2'h2;
   logic miso, miso_oe, gs, gt, rr, cs_p, busy;
   logic [111:0] pix;
   logic [12:0] col;
   logic [11:0] pair;
   logic [55:0] oe;
   logic [15:0] q;
   logic [7:0] bclk;   // Bank clocks
   logic [55:0] lanes;   // Bank data lanes
   logic [4:0] up0, up7;   // Upper halves of banks 0 and 7
   logic [9:0] e0, e7;   // Expected 10 bit words
   int fails = 0, n_tests = 0, cyc = 0, n_gs, n_gt, n_rr, n_cv;
   int k = -1, n_lines = 0;   // Slot within row, rows seen
   // Core clock, 40 ns
   initial forever #20 clk = ~clk;
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         fails++;
         test_done();
      end
   end
   isr_readout #(.ROW_PIXELS(16'h0020)) isr_readout_i (.core_clk_in(clk), .reset_n_in(rst_n),
      .core_ce_in(1'b1), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
      .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .trigger_in(trig),
      .depth_sel_in(depth), .bank_sel_in(2'h0), .line_pairs_in(12'h002),
      .integ_lines_in(16'h0001), .pixel_data_in(pix), .pixel_col_out(col),
      .pixel_pair_out(pair), .conv_pair_out(), .conv_start_out(cs_p),
      .global_start_out(gs), .global_transfer_out(gt), .row_reset_out(rr),
      .row_reset_pair_out(), .bank_clk_out(bclk), .lane_data_out(lanes), .lane_oe_out(oe),
      .frame_busy_out(busy));
   isr_pix_src isr_pix_src_i (.col_in(col), .pair_in(pair), .data_out(pix));
   // ----------------------------------------
   // Far-end deserialiser, banks 0 and 7
   // ----------------------------------------
   // Upper half while the bank clock is low, lower half when it is high
   always @(negedge clk)
   begin
      if (bclk[0] === 1'b0)
      begin
         up0 = lanes[4:0];
         up7 = lanes[53:49];
      end
      else if (k >= 0)
      begin
         // Expected word for slot k of a two-row frame at 10 bit
         case (k)
            3: e0 = (n_lines % 2 == 0) ? 10'h001 : 10'h002;
            12: e0 = 10'h3ff;
            15: e0 = (n_lines % 2 == 1) ? 10'h008 : 10'h004;
            default: e0 = (k > 3 && k < 12) ? 10'((k - 4) * 4) : 10'h000;
         endcase
         // Odd-row bank 7 carries the fourth column of each group
         e7 = (k > 3 && k < 12) ? e0 + 10'h003 : e0;
         chk({up0, lanes[4:0]}, e0);
         chk({up7, lanes[53:49]}, e7);
         k = (k == 15) ? -1 : k + 1;
         if (k < 0)
            n_lines++;
      end
      else if ({up0, lanes[4:0]} === 10'h3ff)
         k = 1;   // Leading sync word opens a row
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compare and count
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One 32 bit SPI frame at 125 ns per bit, MISO taken on rising edges
   task automatic spi(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] w;
      w = {a, d};
      cs_n = 0;
      for (int i = 31; i >= 0; i--)
      begin
         mosi = w[i];
         #62.5 sclk = 1;
         if (i < 16) q[i] = miso;
         if (i == 0) chk(miso_oe, !a[0]);
         #62.5 sclk = 0;
      end
      #62.5 cs_n = 1;
      repeat (12) @(posedge clk);
   endtask
   // Start one triggered frame and count shutter pulses until idle
   task automatic frame();
      int n0;
      n0 = n_lines;
      n_cv = 0;
      n_gs = 0;
      n_gt = 0;
      n_rr = 0;
      @(posedge clk) #2 trig = 1;
      for (int i = 0; i < 4000 && !(trig == 0 && busy === 1'b0); i++)
      begin
         @(posedge clk) #2;
         if (busy === 1'b1) trig = 0;
         n_gs += (gs === 1'b1);
         n_gt += (gt === 1'b1);
         n_rr += (rr === 1'b1);
         n_cv += (cs_p === 1'b1);
      end
      chk(n_cv, 2);
      chk(n_lines - n0, 2);
   endtask
   // Verdict
   task automatic test_done();
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      #2 rst_n = 0;
      cs_n = 1;
      repeat (10) @(posedge clk);
      #2 rst_n = 1;
      repeat (4) @(posedge clk);
      spi(16'h01d0, 16'h0000); chk(q, 16'h0000);
      spi(16'h4018, 16'h0000); chk(q, 16'h0000);
      spi(16'h01d1, 16'h0001); spi(16'h01d0, 16'h0002); chk(q, 16'h0001);
      spi(16'h0200, 16'h0000); chk(q, 16'h0000);
      for (int d = 0; d < 4; d++)
      begin
         @(posedge clk) #2 depth = 2'(d);
         repeat (3) @(posedge clk);
         chk(oe, {8{7'(7'h7f >> d)}});
      end
      @(posedge clk) #2 depth = 2'h2;
      frame(); chk(busy, 1'b0); chk(n_gs, 0); chk(n_rr != 0, 1'b1);
      spi(16'h01d1, 16'h0000);
      frame(); chk(n_gs, 1); chk(n_gt, 1); chk(n_rr, 0);
      spi(16'h4019, 16'h0003);
      repeat (400) @(posedge clk);
      spi(16'h4018, 16'h0000); chk(q, 16'h0013);
      spi(16'h4019, 16'h0000);
      repeat (2000) @(posedge clk);
      spi(16'h4018, 16'h0000); chk(q, 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire

// ### isr_pix_src.sv
// Pixel source model standing behind the readout block's pixel request port.
// Assumes the block samples the answer one core cycle after pixel_col_out moves.
`default_nettype none
module isr_pix_src
(
   // Request from the block, answer to it
   input wire logic [12:0] col_in,
   input wire logic [11:0] pair_in,
   output logic [111:0] data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Each bank pair answers its own column; odd banks mark the odd row
   always_comb
   begin
      for (int b = 0; b < 8; b++)
      begin
         data_out[14*b +: 14] = 14'(col_in + 13'(b >> 1)) ^ {b[0], pair_in[0], 12'h000};
      end
   end
endmodule
`default_nettype wire

// ### isr_pkg.sv
// Types shared by the frame readout block.
// Assumes nothing beyond the constants header.
`default_nettype none

package isr_pkg;
   // Frame sequencer states, Gray coded along idle-integ-read-gap
   typedef enum logic [1:0] {
      ISR_IDLE = 2'h0,
      ISR_INTEG = 2'h1,
      ISR_READ = 2'h3,
      ISR_GAP = 2'h2
   } isr_state_t;
endpackage

`default_nettype wire

// ### isr_readout.sv
// Frame timing, shutter control, SPI registers and DDR bank output.
// Assumes SPI mode 0 framing of 16 address + 16 data bits, MSB first,
// and a pixel source that answers pixel_col_out within one core cycle.
//
// Contract
// - Odd address writes, even address reads
// - Sync words start and end every row
// - Next pair converts while current pair outputs
// - Line period is max of conversion, output
// - Line period independent of shutter mode
// - Two rows out, one to four banks each
// - Frame timing counted in row-pair lines
// - Frame: integration, readout, vertical gap phases
// - Long integration stretches vertical gap
// - Short integration starts late, ending at readout
// - Readout starts right after integration ends
// - Global shutter: all pixels integrate together
// - Shutter mode in low bits of 01D1h
// - Start on held trigger or free-run write
// - Trigger held at integ start repeats frame
// - Rolling shutter: equal, staggered row integration
// - Default vertical gap is one line
// - Seven lanes per bank, five at 10 bit
// - Unused lanes held high impedance
// - Bank count 8, 4 or 2
// - Upper half on fall, lower on rise
// - Lane n: bit n rise, n+half fall
// - Even rows even banks, odd rows odd
// - Left to right, consecutive columns per cycle
// - All four start and end codes per bank
`include "isr_regs.svh"
`default_nettype none

module isr_readout #(
   parameter logic [15:0] ROW_PIXELS = `ISR_ROW_PIXELS
) (
   // Core clock, reset, enable
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic core_ce_in,
   // SPI register port
   input wire logic spi_sclk_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_mosi_in,
   output logic spi_miso_out,
   output logic spi_miso_oe_out,
   // Frame request pin
   input wire logic trigger_in,
   // Static configuration
   input wire logic [1:0] depth_sel_in,
   input wire logic [1:0] bank_sel_in,
   input wire logic [11:0] line_pairs_in,
   input wire logic [15:0] integ_lines_in,
   // Pixel source
   input wire logic [111:0] pixel_data_in,
   output logic [12:0] pixel_col_out,
   output logic [11:0] pixel_pair_out,
   output logic [11:0] conv_pair_out,
   output logic conv_start_out,
   // Shutter control
   output logic global_start_out,
   output logic global_transfer_out,
   output logic row_reset_out,
   output logic [11:0] row_reset_pair_out,
   // Output banks
   output logic [7:0] bank_clk_out,
   output logic [55:0] lane_data_out,
   output logic [55:0] lane_oe_out,
   // Status
   output logic frame_busy_out
);

   // ----------------------------------------
   // SPI domain
   // ----------------------------------------
   logic [4:0] spi_cnt;   // Bit index in frame
   logic [30:0] spi_shift;   // Incoming bits
   logic [15:0] spi_addr;   // Captured address
   logic [15:0] spi_rd;   // Read word
   logic [15:0] spi_waddr;   // Held frame address
   logic [15:0] spi_wdata;   // Held frame data
   logic spi_tog;   // Frame-complete toggle
   logic spi_busy_s1;   // Busy synchroniser
   logic spi_busy_s2;
   logic [15:0] shutter_mode_select;   // Core-domain registers
   logic [15:0] run_state_control;

   // Bit counter, cleared while deselected
   always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in)
   begin
      if (spi_cs_n_in)
         spi_cnt <= 5'h00;
      else
         spi_cnt <= spi_cnt + 5'h01;
   end

   // Shift in, capture address, hand over completed frames
   always_ff @(posedge spi_sclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         spi_shift <= 31'h0;
         spi_addr <= 16'h0000;
         spi_rd <= 16'h0000;
         spi_waddr <= 16'h0000;
         spi_wdata <= 16'h0000;
         spi_tog <= 1'b0;
      end
      else if (!spi_cs_n_in)
      begin
         spi_shift <= {spi_shift[29:0], spi_mosi_in};
         // Address done: even address selects a read word
         if (spi_cnt == 5'h0f)
         begin
            spi_addr <= {spi_shift[14:0], spi_mosi_in};
            if ({spi_shift[14:0], spi_mosi_in} == (`ISR_SHUTTER_ADDR & 16'hfffe))
               spi_rd <= shutter_mode_select;
            else if ({spi_shift[14:0], spi_mosi_in} == (`ISR_RUNCTL_ADDR & 16'hfffe))
               spi_rd <= run_state_control | (16'(spi_busy_s2) << `ISR_BUSY_BIT);
            else
               spi_rd <= 16'h0000;   // Unmapped reads as zero
         end
         // Full frame: hold words and flag the core
         if (spi_cnt == 5'h1f)
         begin
            spi_waddr <= spi_shift[30:15];
            spi_wdata <= {spi_shift[14:0], spi_mosi_in};
            spi_tog <= ~spi_tog;
         end
      end
   end

   // Busy level into the SPI domain
   always_ff @(posedge spi_sclk_in)
   begin
      spi_busy_s1 <= frame_busy_out;
      spi_busy_s2 <= spi_busy_s1;
   end

   // Read data out on falling edges, driven only for reads
   always_ff @(negedge spi_sclk_in or posedge spi_cs_n_in)
   begin
      if (spi_cs_n_in)
      begin
         spi_miso_out <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end
      else
      begin
         spi_miso_out <= spi_cnt[4] & spi_rd[~spi_cnt[3:0]];
         spi_miso_oe_out <= spi_cnt[4] & ~spi_addr[0];
      end
   end

   // ----------------------------------------
   // Core domain: crossing and registers
   // ----------------------------------------
   logic wt_s1, wt_s2, wt_s3;   // Toggle synchroniser and edge
   logic tr_s1, tr_s2;   // Trigger synchroniser
   logic wr_evt;   // One frame arrived
   logic frame_req;   // Trigger held or free run

   assign wr_evt = wt_s2 ^ wt_s3;
   assign frame_req = tr_s2 | (run_state_control == `ISR_RUN_FREE);

   // Synchronisers
   always_ff @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         {wt_s1, wt_s2, wt_s3} <= 3'h0;
         {tr_s1, tr_s2} <= 2'h0;
      end
      else if (core_ce_in)
      begin
         {wt_s1, wt_s2, wt_s3} <= {spi_tog, wt_s1, wt_s2};
         {tr_s1, tr_s2} <= {trigger_in, tr_s1};
      end
   end

   // Register writes, odd addresses only
   always_ff @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         shutter_mode_select <= `ISR_SHUTTER_RST;
         run_state_control <= `ISR_RUNCTL_RST;
      end
      else if (core_ce_in && wr_evt && spi_waddr[0])
      begin
         if (spi_waddr == `ISR_SHUTTER_ADDR)
            shutter_mode_select <= spi_wdata;
         else if (spi_waddr == `ISR_RUNCTL_ADDR)
            run_state_control <= spi_wdata;
      end
   end

   // ----------------------------------------
   // Line and frame arithmetic
   // ----------------------------------------
   logic [1:0] bsel;   // Bank selection, 3 folds to 8 banks
   logic [1:0] nb_log;   // Log2 of banks per converter
   logic [15:0] px_per_bank;   // Pixel slots per bank per row
   logic [15:0] out_cyc;   // Output time of one line
   logic [15:0] line_len;   // Line period in core cycles
   logic [15:0] rd_lines;   // Readout lines
   logic [15:0] integ;   // Integration lines, at least one
   logic [15:0] frame_len;   // Frame period in lines
   logic [15:0] integ_at;   // Frame line where integration starts
   logic global_mode;

   assign bsel = (bank_sel_in == 2'h3) ? 2'h0 : bank_sel_in;
   assign nb_log = 2'h2 - bsel;
   assign px_per_bank = ROW_PIXELS >> nb_log;
   assign out_cyc = {px_per_bank[14:0], 1'b0} + `ISR_OUT_EXTRA;
   assign line_len = (out_cyc > `ISR_CONV_CYC) ? out_cyc : `ISR_CONV_CYC;
   assign rd_lines = {4'h0, line_pairs_in};
   assign integ = (integ_lines_in == 16'h0000) ? 16'h0001 : integ_lines_in;
   assign frame_len = ((rd_lines + `ISR_VGAP_LINES) > integ) ?
                      (rd_lines + `ISR_VGAP_LINES) : integ;
   assign integ_at = frame_len - integ;
   assign global_mode = (shutter_mode_select[1:0] == `ISR_SHUTTER_GLOBAL);

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   isr_pkg::isr_state_t state, next_state;
   logic [15:0] line_cyc;   // Cycle within line
   logic [15:0] line_no;   // Line within phase
   logic [15:0] frame_line;   // Line within frame
   logic [15:0] next_fl;
   logic line_tick;   // Last cycle of a line
   logic pending;   // Next frame integrating
   logic integ_go;   // Integration begins this tick
   logic read_go;   // Readout line begins this tick

   assign line_tick = (line_cyc == line_len - 16'h0001);

   // Next state and line bookkeeping
   always_comb
   begin
      next_state = state;
      next_fl = frame_line + 16'h0001;
      integ_go = 1'b0;
      case (state)
         isr_pkg::ISR_IDLE:
         begin
            next_fl = 16'h0000;
            if (frame_req)
            begin
               next_state = isr_pkg::ISR_INTEG;
               integ_go = 1'b1;
            end
         end
         isr_pkg::ISR_INTEG:
         begin
            next_fl = 16'h0000;
            if (line_no == integ - 16'h0001)
               next_state = isr_pkg::ISR_READ;
         end
         isr_pkg::ISR_READ:
            if (line_no == rd_lines - 16'h0001)
               next_state = isr_pkg::ISR_GAP;
         isr_pkg::ISR_GAP:
            if (frame_line == frame_len - 16'h0001)
            begin
               next_fl = 16'h0000;
               next_state = pending ? isr_pkg::ISR_READ : isr_pkg::ISR_IDLE;
            end
         default:
            next_state = isr_pkg::ISR_IDLE;
      endcase
      // Next frame integration start point
      if (state != isr_pkg::ISR_IDLE && next_state != isr_pkg::ISR_IDLE &&
          next_fl == integ_at && frame_req && next_state != isr_pkg::ISR_INTEG)
         integ_go = 1'b1;
   end

   assign read_go = line_tick && next_state == isr_pkg::ISR_READ;

   // Line timer and state registers
   always_ff @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         line_cyc <= 16'h0000;
         state <= isr_pkg::ISR_IDLE;
         line_no <= 16'h0000;
         frame_line <= 16'h0000;
         pending <= 1'b0;
         frame_busy_out <= 1'b0;
      end
      else if (core_ce_in)
      begin
         line_cyc <= line_tick ? 16'h0000 : line_cyc + 16'h0001;
         if (line_tick)
         begin
            state <= next_state;
            frame_line <= next_fl;
            line_no <= (next_state != state) ? 16'h0000 : line_no + 16'h0001;
            // Set wins over the frame-start clear
            if (integ_go && state != isr_pkg::ISR_IDLE)
               pending <= 1'b1;
            else if (state == isr_pkg::ISR_GAP && next_state != isr_pkg::ISR_GAP)
               pending <= 1'b0;
            frame_busy_out <= (next_state != isr_pkg::ISR_IDLE);
         end
      end
   end

   // ----------------------------------------
   // Shutter and converter strobes
   // ----------------------------------------
   logic [11:0] rst_idx;   // Next pair to reset
   logic rst_act;   // Rolling reset sweep active

   always_ff @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         global_start_out <= 1'b0;
         global_transfer_out <= 1'b0;
         row_reset_out <= 1'b0;
         row_reset_pair_out <= 12'h000;
         rst_idx <= 12'h000;
         rst_act <= 1'b0;
         conv_start_out <= 1'b0;
         conv_pair_out <= 12'h000;
         pixel_pair_out <= 12'h000;
      end
      else if (core_ce_in)
      begin
         // Whole array starts and transfers at once
         global_start_out <= line_tick & integ_go & global_mode;
         global_transfer_out <= read_go & (next_fl == 16'h0000) & global_mode;
         row_reset_out <= 1'b0;
         conv_start_out <= 1'b0;
         // Rolling sweep: one pair reset per line, top to bottom
         if (line_tick && integ_go)
         begin
            row_reset_out <= ~global_mode;
            row_reset_pair_out <= 12'h000;
            rst_idx <= 12'h001;
            rst_act <= (line_pairs_in > 12'h001);
         end
         else if (line_tick && rst_act)
         begin
            row_reset_out <= ~global_mode;
            row_reset_pair_out <= rst_idx;
            rst_idx <= rst_idx + 12'h001;
            rst_act <= (rst_idx + 12'h001 < line_pairs_in);
         end
         // Pair k streams out while pair k+1 converts
         if (read_go)
         begin
            pixel_pair_out <= (state == isr_pkg::ISR_READ) ? line_no[11:0] + 12'h001 : 12'h000;
            conv_pair_out <= (state == isr_pkg::ISR_READ) ? line_no[11:0] + 12'h002 : 12'h001;
            conv_start_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Row stream engine
   // ----------------------------------------
   logic phase;   // 0: falling half, 1: rising half
   logic st_pend;   // Row waiting for phase alignment
   logic st_run;   // Row streaming
   logic [15:0] slot;   // Word slot within row
   logic first_line, last_line;
   logic [13:0] code_begin, code_end;
   logic [6:0] lane_mask;   // Lanes used at this depth
   logic [2:0] half;

   assign half = 3'h7 - {1'b0, depth_sel_in};
   assign lane_mask = 7'h7f >> depth_sel_in;
   assign code_begin = first_line ? `ISR_CODE_FS : `ISR_CODE_LS;
   assign code_end = last_line ? `ISR_CODE_FE : `ISR_CODE_LE;

   // Slot sequencing: 4 begin codes, pixels, 4 end codes
   always_ff @(posedge core_clk_in)
   begin
      if (!reset_n_in)
      begin
         phase <= 1'b0;
         st_pend <= 1'b0;
         st_run <= 1'b0;
         slot <= 16'h0000;
         first_line <= 1'b0;
         last_line <= 1'b0;
         pixel_col_out <= 13'h0000;
      end
      else if (core_ce_in)
      begin
         phase <= ~phase;
         if (read_go)
         begin
            st_pend <= 1'b1;
            first_line <= (state != isr_pkg::ISR_READ);
            last_line <= (next_state == isr_pkg::ISR_READ) &&
                         (((state == isr_pkg::ISR_READ) ? line_no + 16'h0002 : 16'h0001)
                          == rd_lines);
         end
         else if (st_pend && phase)
         begin
            st_pend <= 1'b0;
            st_run <= 1'b1;
            slot <= 16'h0000;
            pixel_col_out <= 13'h0000;
         end
         else if (st_run && phase)
         begin
            slot <= slot + 16'h0001;
            // Next column group, left to right
            if (slot >= 16'h0003)
               pixel_col_out <= 13'((slot - 16'h0003) << nb_log);
            if (slot == px_per_bank + 16'h0007)
               st_run <= 1'b0;
         end
      end
   end

   // Sync word for slot index within a group of four
   function automatic logic [13:0] sync_word(input logic [1:0] idx, input logic [13:0] code);
      case (idx)
         2'h0: sync_word = `ISR_SYNC_LEAD;
         2'h3: sync_word = code;
         default: sync_word = 14'h0000;
      endcase
   endfunction

   // ----------------------------------------
   // Per-bank DDR serialiser
   // ----------------------------------------
   genvar b;
   generate
      for (b = 0; b < `ISR_BANKS; b = b + 1)
      begin : g_bank
         logic [13:0] hold;   // Word for the rising half
         logic [13:0] word;
         logic active;
         // Even banks carry even rows, odd banks odd rows
         assign active = (3'(b >> 1) < (3'h1 << nb_log));
         always_comb
         begin
            if (!st_run)
               word = 14'h0000;
            else if (slot < 16'h0004)
               word = sync_word(slot[1:0], code_begin);
            else if (slot < px_per_bank + 16'h0004)
               word = pixel_data_in[b * `ISR_PIX_W +: `ISR_PIX_W];
            else
               word = sync_word(2'(slot - px_per_bank), code_end);
         end
         always_ff @(posedge core_clk_in)
         begin
            if (!reset_n_in)
            begin
               hold <= 14'h0000;
               bank_clk_out[b] <= 1'b1;
               lane_data_out[b * `ISR_LANES +: `ISR_LANES] <= 7'h00;
               lane_oe_out[b * `ISR_LANES +: `ISR_LANES] <= 7'h00;
            end
            else if (core_ce_in)
            begin
               bank_clk_out[b] <= phase & active;
               lane_oe_out[b * `ISR_LANES +: `ISR_LANES] <= active ? lane_mask : 7'h00;
               if (!phase)
               begin
                  hold <= word;
                  // Upper half leaves with the falling edge
                  lane_data_out[b * `ISR_LANES +: `ISR_LANES] <=
                     active ? 7'(word >> half) & lane_mask : 7'h00;
               end
               else
                  lane_data_out[b * `ISR_LANES +: `ISR_LANES] <=
                     active ? hold[6:0] & lane_mask : 7'h00;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in || !core_ce_in);

   a_read_addr_ignored: assert property (
      wr_evt && !spi_waddr[0] |=> $stable(shutter_mode_select) && $stable(run_state_control))
      else $error("even address changed a register");
   a_line_period_len: assert property (
      line_tick |-> line_cyc + 16'h0001 >= `ISR_CONV_CYC && line_cyc + 16'h0001 >= out_cyc)
      else $error("line period shorter than needed");
   a_gap_frame_len: assert property (
      line_tick && state == isr_pkg::ISR_GAP && next_state != isr_pkg::ISR_GAP
      |-> frame_line + 16'h0001 == frame_len && frame_len >= integ)
      else $error("frame length wrong");
   a_integ_then_read: assert property (
      line_tick && state == isr_pkg::ISR_INTEG && line_no == integ - 16'h0001
      |=> state == isr_pkg::ISR_READ && global_transfer_out == global_mode)
      else $error("readout did not follow integration");
   a_global_no_rows: assert property (
      global_mode && $stable(shutter_mode_select) |=> !row_reset_out)
      else $error("row reset in global mode");
   a_rolling_one_row: assert property (
      row_reset_out |=> !row_reset_out [*2])
      else $error("row resets too close");
   a_trigger_repeats: assert property (
      line_tick && integ_go && state != isr_pkg::ISR_IDLE |=> pending)
      else $error("held request did not repeat frame");
   a_idle_waits: assert property (
      state == isr_pkg::ISR_IDLE && !tr_s2 && run_state_control != `ISR_RUN_FREE
      |=> state == isr_pkg::ISR_IDLE)
      else $error("frame started without request");
   a_unused_lanes_off: assert property (
      $stable(depth_sel_in) |-> (lane_oe_out[6:0] & ~lane_mask) == 7'h00)
      else $error("unused lane driven");

endmodule

`default_nettype wire

// ### isr_regs.svh
// Constants for the frame readout block: register offsets, codes, timing.
// Assumes a 25 MHz core clock; included by the readout module only.
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH

// ----------------------------------------
// Register map (write offsets, 16 bit)
// ----------------------------------------
`define ISR_SHUTTER_ADDR 16'h01d1
`define ISR_RUNCTL_ADDR 16'h4019
`define ISR_SHUTTER_RST 16'h0000
`define ISR_RUNCTL_RST 16'h0000
`define ISR_RUN_FREE 16'h0003
`define ISR_SHUTTER_GLOBAL 2'h0
`define ISR_BUSY_BIT 4

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ISR_BANKS 8
`define ISR_LANES 7
`define ISR_PIX_W 14
`define ISR_ROW_PIXELS 16'h0fa0
`define ISR_VGAP_LINES 16'h0001

// ----------------------------------------
// Timing
// ----------------------------------------
`define ISR_CLK_NS 40
`define ISR_CONV_NS 8660
`define ISR_CONV_CYC 16'((`ISR_CONV_NS + `ISR_CLK_NS - 1) / `ISR_CLK_NS)
`define ISR_OUT_EXTRA 16'h0012

// ----------------------------------------
// Sync words (four per boundary)
// ----------------------------------------
`define ISR_SYNC_LEAD 14'h3fff
`define ISR_CODE_FS 14'h0001
`define ISR_CODE_LS 14'h0002
`define ISR_CODE_LE 14'h0004
`define ISR_CODE_FE 14'h0008

`endif
